// ### hdl/ttu_top.sv
// Purpose : three 8-bit timers on a shared divider, register port
// Assumes : one 200 MHz clock; event pin is asynchronous
// Notes   : reads answer one cycle after the read strobe
`timescale 1ns/100ps
module ttu_top (
	input  wire logic         clk_sys,     // system clock
	input  wire logic         rst,         // synchronous reset
	input  wire ttu_pkg::ttu_bus_t bus_i,  // register request
	output logic [3:0]        rdata_q,     // read data, cycle after read
	input  wire logic         event_pin,   // asynchronous event input
	output logic              pulse_q,     // pulse output pin
	output logic              irq_a_q,     // timer a overflow pulse
	output logic              irq_b_q,     // timer b overflow/capture
	output logic              irq_c_q,     // timer c overflow pulse
	output logic              wdog_q       // watchdog runaway pulse
);

	// ****************************************************************
	// registers
	// ****************************************************************
	localparam int DW = ttu_pkg::DIV_WIDTH;
	logic [3:0]  pin_func_q, ta_mode_q, tb_mode_q, tb_edge_q, tc_mode_q;
	logic [3:0]  ctrl_q;
	logic [3:0]  tb_low_q, tc_low_q;
	logic [7:0]  tb_reload_q, tc_reload_q, tc_duty_q;
	logic [7:0]  ta_cnt_q, tb_cnt_q, tc_cnt_q;
	logic [DW-1:0] div_q;
	logic        ev_s1_q, ev_s2_q, ev_s3_q;
	logic        tb_load, tc_load, stop, clr;
	logic        ta_tick, tb_tick, tc_tick, ev_edge;
	logic        ta_ovf, tb_ovf, tc_ovf;
	logic        pwm_q;

	// map a three-bit select code onto a one-cycle divider tick
	function automatic logic tap_tick(input logic [2:0] sel,
	                                  input logic [DW-1:0] div);
		logic [3:0] t;
		t = ttu_pkg::TAP_0;
		unique case (sel)
			3'h0: t = ttu_pkg::TAP_0;
			3'h1: t = ttu_pkg::TAP_1;
			3'h2: t = ttu_pkg::TAP_2;
			3'h3: t = ttu_pkg::TAP_3;
			3'h4: t = ttu_pkg::TAP_4;
			3'h5: t = ttu_pkg::TAP_5;
			3'h6: t = ttu_pkg::TAP_6;
			3'h7: t = ttu_pkg::TAP_7;
		endcase
		// tick when all bits below the tap are ones
		tap_tick = &(div | ~((DW'(1) << t) - DW'(1)));
	endfunction : tap_tick

	assign stop    = ctrl_q[ttu_pkg::STOP_BIT];
	assign clr     = rst | stop;
	assign tb_load = bus_i.wr & (bus_i.addr == ttu_pkg::ADDR_TB_HIGH);
	assign tc_load = bus_i.wr & (bus_i.addr == ttu_pkg::ADDR_TC_HIGH);

	// ****************************************************************
	// register writes
	// ****************************************************************
	// control register survives stop so software can leave it
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl_q <= ttu_pkg::REG_RESET;
		end else if (bus_i.wr && bus_i.addr == ttu_pkg::ADDR_CTRL) begin
			ctrl_q <= bus_i.wdata;
		end
	end

	// stop clears mode and pin selection
	always_ff @(posedge clk_sys) begin
		if (clr) begin
			pin_func_q <= ttu_pkg::REG_RESET;
			ta_mode_q  <= ttu_pkg::REG_RESET;
			tb_mode_q  <= ttu_pkg::REG_RESET;
			tb_edge_q  <= ttu_pkg::REG_RESET;
			tc_mode_q  <= ttu_pkg::REG_RESET;
			tb_low_q   <= ttu_pkg::REG_RESET;
			tc_low_q   <= ttu_pkg::REG_RESET;
		end else if (bus_i.wr) begin
			unique case (bus_i.addr)
				ttu_pkg::ADDR_PIN_FUNC:    pin_func_q <= bus_i.wdata;
				ttu_pkg::ADDR_TA_MODE:     ta_mode_q  <= bus_i.wdata;
				ttu_pkg::ADDR_TB_MODE_ONE: tb_mode_q  <= bus_i.wdata;
				ttu_pkg::ADDR_TB_EDGE:     tb_edge_q  <= bus_i.wdata;
				ttu_pkg::ADDR_TC_MODE:     tc_mode_q  <= bus_i.wdata;
				ttu_pkg::ADDR_TB_LOW:      tb_low_q   <= bus_i.wdata;
				ttu_pkg::ADDR_TC_LOW:      tc_low_q   <= bus_i.wdata;
				default: ;
			endcase
		end
	end

	// reload values latched on the upper nibble write
	always_ff @(posedge clk_sys) begin
		if (clr) begin
			tb_reload_q <= ttu_pkg::CNT_RESET;
			tc_reload_q <= ttu_pkg::CNT_RESET;
		end else begin
			if (tb_load) begin
				tb_reload_q <= {bus_i.wdata, tb_low_q};
			end
			if (tc_load) begin
				tc_reload_q <= {bus_i.wdata, tc_low_q};
			end
		end
	end

	// ****************************************************************
	// read port
	// ****************************************************************
	// readback pairs show the live counters
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata_q <= ttu_pkg::REG_RESET;
		end else if (bus_i.rd) begin
			unique case (bus_i.addr)
				ttu_pkg::ADDR_PIN_FUNC:    rdata_q <= pin_func_q;
				ttu_pkg::ADDR_TA_MODE:     rdata_q <= ta_mode_q;
				ttu_pkg::ADDR_TB_MODE_ONE: rdata_q <= tb_mode_q;
				ttu_pkg::ADDR_TB_EDGE:     rdata_q <= tb_edge_q;
				ttu_pkg::ADDR_TC_MODE:     rdata_q <= tc_mode_q;
				ttu_pkg::ADDR_CTRL:        rdata_q <= ctrl_q;
				ttu_pkg::ADDR_TB_LOW:      rdata_q <= tb_cnt_q[3:0];
				ttu_pkg::ADDR_TB_HIGH:     rdata_q <= tb_cnt_q[7:4];
				ttu_pkg::ADDR_TC_LOW:      rdata_q <= tc_cnt_q[3:0];
				ttu_pkg::ADDR_TC_HIGH:     rdata_q <= tc_cnt_q[7:4];
				default:                   rdata_q <= 4'h0;
			endcase
		end else begin
			rdata_q <= 4'h0;
		end
	end

	// ****************************************************************
	// shared divider and event pin
	// ****************************************************************
	// free-running divider feeding every timer
	always_ff @(posedge clk_sys) begin
		if (clr) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + DW'(1);
		end
	end

	// two-stage synchroniser, third stage for edge detection
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ev_s1_q <= 1'b0;
			ev_s2_q <= 1'b0;
			ev_s3_q <= 1'b0;
		end else begin
			ev_s1_q <= event_pin;
			ev_s2_q <= ev_s1_q;
			ev_s3_q <= ev_s2_q;
		end
	end

	always_comb begin
		ev_edge = 1'b0;
		unique case (ttu_pkg::ttu_edge_t'(tb_edge_q[1:0]))
			ttu_pkg::EDGE_NONE: ev_edge = 1'b0;
			ttu_pkg::EDGE_FALL: ev_edge = ev_s3_q & ~ev_s2_q;
			ttu_pkg::EDGE_RISE: ev_edge = ~ev_s3_q & ev_s2_q;
			ttu_pkg::EDGE_BOTH: ev_edge = ev_s3_q ^ ev_s2_q;
		endcase
	end

	assign ta_tick = tap_tick(ta_mode_q[2:0], div_q);
	// seven taps or the event pin as timer b source
	assign tb_tick = (tb_mode_q[2:0] == ttu_pkg::TB_EVENT_SEL &&
	                  !tb_mode_q[ttu_pkg::RELOAD_BIT]) ? ev_edge :
	                 (tb_mode_q[2:0] == ttu_pkg::TB_EVENT_SEL) ? ev_edge :
	                 tap_tick(tb_mode_q[2:0], div_q);
	assign tc_tick = tap_tick(tc_mode_q[2:0], div_q);

	assign ta_ovf = ta_tick && ta_cnt_q == ttu_pkg::CNT_TOP;
	assign tb_ovf = tb_tick && tb_cnt_q == ttu_pkg::CNT_TOP;
	assign tc_ovf = tc_tick && tc_cnt_q == ttu_pkg::CNT_TOP;

	// ****************************************************************
	// timer a
	// ****************************************************************
	// plain wrap, no load
	always_ff @(posedge clk_sys) begin
		if (clr) begin
			ta_cnt_q <= ttu_pkg::CNT_RESET;
		end else if (ta_tick) begin
			ta_cnt_q <= ta_cnt_q + 8'h01;
		end
	end

	// ****************************************************************
	// timer b
	// ****************************************************************
	// free-running, reload and capture share one counter
	always_ff @(posedge clk_sys) begin
		if (clr) begin
			tb_cnt_q <= ttu_pkg::CNT_RESET;
		end else if (tb_load) begin
			tb_cnt_q <= {bus_i.wdata, tb_low_q};
		// capture mode restarts from zero on each trigger
		end else if (tb_edge_q[ttu_pkg::CAPTURE_BIT + 2] && ev_edge) begin
			tb_cnt_q <= ttu_pkg::CNT_RESET;
		end else if (tb_edge_q[ttu_pkg::CAPTURE_BIT + 2]) begin
			if (tap_tick(tb_mode_q[2:0], div_q)) begin
				tb_cnt_q <= tb_cnt_q + 8'h01;
			end
		end else if (tb_ovf) begin
			tb_cnt_q <= tb_mode_q[ttu_pkg::RELOAD_BIT] ? tb_reload_q
			                                            : ttu_pkg::CNT_RESET;
		end else if (tb_tick) begin
			tb_cnt_q <= tb_cnt_q + 8'h01;
		end
	end

	// ****************************************************************
	// timer c and pwm
	// ****************************************************************
	always_ff @(posedge clk_sys) begin
		if (clr) begin
			tc_cnt_q <= ttu_pkg::CNT_RESET;
		end else if (tc_load) begin
			tc_cnt_q <= {bus_i.wdata, tc_low_q};
		end else if (tc_ovf) begin
			tc_cnt_q <= tc_mode_q[ttu_pkg::RELOAD_BIT] ? tc_reload_q
			                                            : ttu_pkg::CNT_RESET;
		end else if (tc_tick) begin
			tc_cnt_q <= tc_cnt_q + 8'h01;
		end
	end

	// duty threshold only adopted at overflow, so a new
	// setting shows from the next period; the current one is odd
	always_ff @(posedge clk_sys) begin
		if (clr) begin
			tc_duty_q <= ttu_pkg::CNT_RESET;
			pwm_q     <= 1'b0;
		end else begin
			if (tc_ovf) begin
				tc_duty_q <= tc_reload_q;
			end
			pwm_q <= (tc_cnt_q > tc_duty_q);
		end
	end

	// pulse pin gated by the pin function bit
	always_ff @(posedge clk_sys) begin
		if (clr) begin
			pulse_q <= 1'b0;
		end else begin
			pulse_q <= pwm_q & pin_func_q[ttu_pkg::PULSE_SEL_BIT];
		end
	end

	// ****************************************************************
	// requests
	// ****************************************************************
	always_ff @(posedge clk_sys) begin
		if (clr) begin
			irq_a_q <= 1'b0;
			irq_b_q <= 1'b0;
			irq_c_q <= 1'b0;
			wdog_q  <= 1'b0;
		end else begin
			irq_a_q <= ta_ovf;
			irq_b_q <= (tb_ovf && !tb_edge_q[ttu_pkg::CAPTURE_BIT + 2]) ||
			           (tb_edge_q[ttu_pkg::CAPTURE_BIT + 2] && ev_edge);
			irq_c_q <= tc_ovf;
			// unserviced overflow in watchdog mode is runaway
			wdog_q  <= tc_ovf & tc_mode_q[ttu_pkg::WDOG_BIT] & ~tc_load;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	// capture trigger seen, and what must follow one cycle later
	sequence seq_capture_edge;
		tb_edge_q[ttu_pkg::CAPTURE_BIT + 2] && ev_edge && !tb_load;
	endsequence
	sequence seq_capture_done;
		irq_b_q && tb_cnt_q == ttu_pkg::CNT_RESET;
	endsequence

	chk_ta_irq_ovf: assert property (@(posedge clk_sys) disable iff (clr)
		ta_ovf |=> irq_a_q) else $error("timer a overflow lost");
	chk_ta_wrap: assert property (@(posedge clk_sys) disable iff (clr)
		ta_ovf |=> ta_cnt_q == 8'h00) else $error("timer a no wrap");
	chk_tb_reload: assert property (@(posedge clk_sys) disable iff (clr)
		tb_ovf && tb_mode_q[3] && !tb_load && !tb_edge_q[2]
		|=> tb_cnt_q == $past(tb_reload_q)) else $error("timer b no reload");
	chk_tb_load_hi: assert property (@(posedge clk_sys) disable iff (clr)
		tb_load |=> tb_cnt_q == {$past(bus_i.wdata), $past(tb_low_q)})
		else $error("timer b load wrong");
	chk_tb_readback: assert property (@(posedge clk_sys) disable iff (clr)
		bus_i.rd && bus_i.addr == 6'h0a |=> rdata_q == $past(tb_cnt_q[3:0]))
		else $error("timer b readback wrong");
	chk_tb_capture_irq: assert property (@(posedge clk_sys) disable iff (clr)
		seq_capture_edge |=> seq_capture_done)
		else $error("capture trigger missed");
	chk_tc_irq_ovf: assert property (@(posedge clk_sys) disable iff (clr)
		tc_ovf |=> irq_c_q) else $error("timer c overflow lost");
	chk_pulse_gate: assert property (@(posedge clk_sys) disable iff (clr)
		!pin_func_q[2] |=> !pulse_q) else $error("pulse pin not gated");
	chk_stop_clear: assert property (@(posedge clk_sys) disable iff (rst)
		stop |=> ta_cnt_q == 8'h00 && pin_func_q == 4'h0)
		else $error("stop did not clear");

	// servicing the watchdog means a load before the count tops out
	chk_wdog_runaway: assert property (@(posedge clk_sys)
		disable iff (clr) tc_ovf && tc_mode_q[ttu_pkg::WDOG_BIT] && !tc_load
		|=> wdog_q) else $error("watchdog runaway missed");
	chk_tc_reload: assert property (@(posedge clk_sys)
		disable iff (clr) tc_ovf && tc_mode_q[ttu_pkg::RELOAD_BIT] && !tc_load
		|=> tc_cnt_q == $past(tc_reload_q)) else $error("timer c no reload");
	chk_tb_free_wrap: assert property (@(posedge clk_sys)
		disable iff (clr) tb_ovf && !tb_mode_q[ttu_pkg::RELOAD_BIT] && !tb_load
		&& !tb_edge_q[2] |=> tb_cnt_q == ttu_pkg::CNT_RESET)
		else $error("timer b no wrap");
	chk_tc_load_hi: assert property (@(posedge clk_sys)
		disable iff (clr) tc_load
		|=> tc_cnt_q == {$past(bus_i.wdata), $past(tc_low_q)})
		else $error("timer c load wrong");
	chk_tc_readback: assert property (@(posedge clk_sys)
		disable iff (clr) bus_i.rd && bus_i.addr == ttu_pkg::ADDR_TC_HIGH
		|=> rdata_q == $past(tc_cnt_q[7:4]))
		else $error("timer c readback wrong");
	// duty changes only at an overflow
	chk_pwm_duty_adopt: assert property (@(posedge clk_sys)
		disable iff (clr) tc_ovf |=> tc_duty_q == $past(tc_reload_q))
		else $error("pwm duty not adopted");
	chk_pwm_duty_hold: assert property (@(posedge clk_sys)
		disable iff (clr) !tc_ovf |=> $stable(tc_duty_q))
		else $error("pwm duty moved between overflows");
	chk_rdata_idle: assert property (@(posedge clk_sys)
		disable iff (clr) !bus_i.rd |=> rdata_q == ttu_pkg::REG_RESET)
		else $error("read data outside read slot");
	chk_ta_irq_cause: assert property (@(posedge clk_sys)
		disable iff (clr) irq_a_q |-> $past(ta_ovf))
		else $error("timer a request without overflow");

endmodule : ttu_top

// ### hdl/ttu_pkg.sv
// Purpose : constants and types shared by the triple timer unit
// Assumes : 4-bit register data, 6-bit register addresses
// Notes   : offsets are the printed register addresses
package ttu_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [5:0] ADDR_PIN_FUNC    = 6'h04;
	localparam logic [5:0] ADDR_TA_MODE     = 6'h08;
	localparam logic [5:0] ADDR_TB_MODE_ONE = 6'h09;
	localparam logic [5:0] ADDR_TB_LOW      = 6'h0a;
	localparam logic [5:0] ADDR_TB_HIGH     = 6'h0b;
	localparam logic [5:0] ADDR_TC_MODE     = 6'h0d;
	localparam logic [5:0] ADDR_TC_LOW      = 6'h0e;
	localparam logic [5:0] ADDR_TC_HIGH     = 6'h0f;
	localparam logic [5:0] ADDR_TB_EDGE     = 6'h26;
	localparam logic [5:0] ADDR_CTRL        = 6'h30;

	// ****************************************************************
	// fields and reset values
	// ****************************************************************
	localparam int        PULSE_SEL_BIT  = 2;
	localparam int        RELOAD_BIT     = 3;
	localparam int        WDOG_BIT       = 3;
	localparam int        CAPTURE_BIT    = 0;
	localparam int        STOP_BIT       = 1;
	localparam logic [2:0] TB_EVENT_SEL  = 3'h7;
	localparam logic [3:0] REG_RESET     = 4'h0;
	localparam logic [7:0] CNT_RESET     = 8'h00;
	localparam logic [7:0] CNT_TOP       = 8'hff;
	localparam int        DIV_WIDTH      = 11;

	// divider tap per select code, as powers of two of the system clock
	localparam logic [3:0] TAP_0 = 4'ha;
	localparam logic [3:0] TAP_1 = 4'h9;
	localparam logic [3:0] TAP_2 = 4'h8;
	localparam logic [3:0] TAP_3 = 4'h7;
	localparam logic [3:0] TAP_4 = 4'h6;
	localparam logic [3:0] TAP_5 = 4'h4;
	localparam logic [3:0] TAP_6 = 4'h2;
	localparam logic [3:0] TAP_7 = 4'h1;

	typedef enum logic [1:0] {
		EDGE_NONE = 2'b00,
		EDGE_FALL = 2'b01,
		EDGE_RISE = 2'b10,
		EDGE_BOTH = 2'b11
	} ttu_edge_t;

	typedef struct packed {
		logic [5:0] addr;
		logic [3:0] wdata;
		logic       wr;
		logic       rd;
	} ttu_bus_t;

endpackage : ttu_pkg

// ### verification/ttu_core_model.sv
// Purpose : processor core model driving the timer register port
// Assumes : bus_o changes just after a rising edge; slave never stalls
// Notes   : read data are taken in the one cycle that they stand
`timescale 1ns/100ps
module ttu_core_model (
	input  wire logic              clk_sys, // system clock
	output ttu_pkg::ttu_bus_t      bus_o,   // register request
	input  wire logic [3:0]        rdata_q  // read data from the block
);
	initial bus_o = '0;

	// clock select is written while the timers keep running
	task automatic wr(input logic [5:0] a, input logic [3:0] d);
		@(posedge clk_sys);
		bus_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus_o.wr <= 1'b0;
	endtask : wr

	// pwm is only judged after an overflow has passed
	task automatic rd(input logic [5:0] a, output logic [3:0] d);
		@(posedge clk_sys);
		bus_o <= '{addr: a, wdata: 4'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus_o.rd <= 1'b0;
		#1 d = rdata_q;
	endtask : rd
endmodule : ttu_core_model

// ### verification/test_triple_timer_unit.sv
// Purpose : self-checking bench for the triple timer unit
// Assumes : 200 MHz clock, divider taps as packaged
// Notes   : overflow spacing is measured between two request pulses
`timescale 1ns/100ps
module test_triple_timer_unit;
	logic              clk_sys;   // system clock
	logic              rst;       // synchronous reset
	ttu_pkg::ttu_bus_t bus;       // register request
	logic [3:0]        rdata_q;   // read data
	logic              event_pin; // event input
	logic              pulse_q;   // pwm pin
	logic              irq_a_q;   // timer a request
	logic              irq_b_q;   // timer b request
	logic              irq_c_q;   // timer c request
	logic              wdog_q;    // watchdog pulse
	int                err_count;
	int                compares;

	ttu_top u_ttu_top (.clk_sys(clk_sys), .rst(rst), .bus_i(bus),
		.rdata_q(rdata_q), .event_pin(event_pin), .pulse_q(pulse_q),
		.irq_a_q(irq_a_q), .irq_b_q(irq_b_q), .irq_c_q(irq_c_q),
		.wdog_q(wdog_q));
	ttu_core_model u_ttu_core_model (.clk_sys(clk_sys), .bus_o(bus),
		.rdata_q(rdata_q));

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	task automatic test_done;
		$display("tests done: %0d compares, %0d mismatches", compares,
			err_count);
		if (err_count == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : test_done

	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
			input string msg);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: %s got %h exp %h", $time, msg, got,
				exp);
		end
	endtask : chk

	task automatic rd8(input logic [5:0] lo, output logic [7:0] v);
		u_ttu_core_model.rd(lo, v[3:0]);
		u_ttu_core_model.rd(lo + 6'h01, v[7:4]);
	endtask : rd8

	function automatic logic pick(input int w);
		case (w)
			0: return irq_a_q;
			1: return irq_b_q;
			2: return irq_c_q;
			default: return wdog_q;
		endcase
	endfunction : pick

	// cycles between two successive pulses of one request line
	task automatic gap(input int w, output int n);
		int i;
		i = 0;
		n = 0;
		do begin
			@(posedge clk_sys);
			#1 i++;
		end while (pick(w) !== 1'b1 && i < 3000);
		do begin
			@(posedge clk_sys);
			#1 n++;
		end while (pick(w) !== 1'b1 && n < 3000);
		if (i >= 3000 || n >= 3000) begin
			err_count++;
			$display("mismatch at %0t: request %0d never came", $time, w);
			test_done();
		end
	endtask : gap

	task automatic t_reset_map;
		logic [3:0] d;
		u_ttu_core_model.rd(ttu_pkg::ADDR_TA_MODE, d);
		chk({4'h0, d}, 8'h00, "mode after reset");
		u_ttu_core_model.wr(6'h3f, 4'h9);
		u_ttu_core_model.rd(6'h3f, d);
		chk({4'h0, d}, 8'h00, "unmapped read");
		u_ttu_core_model.wr(ttu_pkg::ADDR_TC_MODE, 4'h5);
		u_ttu_core_model.rd(ttu_pkg::ADDR_TC_MODE, d);
		chk({4'h0, d}, 8'h05, "mode readback");
		$display("test reset_map done");
	endtask : t_reset_map

	task automatic t_load;
		logic [7:0] v;
		// slow tap on timer c so both nibble reads see one count
		u_ttu_core_model.wr(ttu_pkg::ADDR_TC_MODE, 4'h0);
		u_ttu_core_model.wr(ttu_pkg::ADDR_TB_LOW, 4'h5);
		rd8(ttu_pkg::ADDR_TB_LOW, v);
		chk(v, 8'h00, "low nibble alone loads nothing");
		u_ttu_core_model.wr(ttu_pkg::ADDR_TB_HIGH, 4'ha);
		rd8(ttu_pkg::ADDR_TB_LOW, v);
		chk(v, 8'ha5, "timer b load");
		u_ttu_core_model.wr(ttu_pkg::ADDR_TC_LOW, 4'h3);
		u_ttu_core_model.wr(ttu_pkg::ADDR_TC_HIGH, 4'hc);
		rd8(ttu_pkg::ADDR_TC_LOW, v);
		chk(v, 8'hc3, "timer c load");
		$display("test load done");
	endtask : t_load

	task automatic t_periods;
		int n;
		u_ttu_core_model.wr(ttu_pkg::ADDR_TA_MODE, 4'h7);
		gap(0, n);
		chk(n[7:0], 8'h00, "timer a period low");
		chk(n[15:8], 8'h02, "timer a period high");
		u_ttu_core_model.wr(ttu_pkg::ADDR_TB_LOW, 4'h0);
		u_ttu_core_model.wr(ttu_pkg::ADDR_TB_HIGH, 4'hf);
		u_ttu_core_model.wr(ttu_pkg::ADDR_TB_MODE_ONE, 4'he);
		gap(1, n);
		chk(n[7:0], 8'd64, "timer b reload period");
		u_ttu_core_model.wr(ttu_pkg::ADDR_TB_MODE_ONE, 4'h6);
		gap(1, n);
		chk(n[15:8], 8'h04, "timer b free period");
		$display("test periods done");
	endtask : t_periods

	task automatic t_events;
		logic [7:0] v;
		logic [7:0] exp [4];
		int e;
		exp = '{8'h00, 8'h01, 8'h01, 8'h02};
		u_ttu_core_model.wr(ttu_pkg::ADDR_TB_MODE_ONE, 4'h7);
		for (e = 0; e < 4; e++) begin
			u_ttu_core_model.wr(ttu_pkg::ADDR_TB_EDGE, e[3:0]);
			u_ttu_core_model.wr(ttu_pkg::ADDR_TB_LOW, 4'h0);
			u_ttu_core_model.wr(ttu_pkg::ADDR_TB_HIGH, 4'h0);
			repeat (2) @(posedge clk_sys);
			event_pin <= 1'b1;
			repeat (10) @(posedge clk_sys);
			event_pin <= 1'b0;
			repeat (10) @(posedge clk_sys);
			rd8(ttu_pkg::ADDR_TB_LOW, v);
			chk(v, exp[e], "event count per edge mode");
		end
		$display("test events done");
	endtask : t_events

	task automatic t_capture;
		logic [7:0] v;
		int hits;
		// stop clears the divider, so the slowest tap stays quiet here
		u_ttu_core_model.wr(ttu_pkg::ADDR_CTRL, 4'h2);
		u_ttu_core_model.wr(ttu_pkg::ADDR_CTRL, 4'h0);
		u_ttu_core_model.wr(ttu_pkg::ADDR_TB_EDGE, 4'h6);
		u_ttu_core_model.wr(ttu_pkg::ADDR_TB_LOW, 4'ha);
		u_ttu_core_model.wr(ttu_pkg::ADDR_TB_HIGH, 4'h5);
		hits = 0;
		repeat (2) begin
			@(posedge clk_sys);
			event_pin <= ~event_pin;
			repeat (20) begin
				@(posedge clk_sys);
				#1 hits += (irq_b_q === 1'b1);
			end
		end
		chk(hits[7:0], 8'h01, "one capture request per rise");
		rd8(ttu_pkg::ADDR_TB_LOW, v);
		chk(v, 8'h00, "capture clears counter");
		$display("test capture done");
	endtask : t_capture

	task automatic t_timer_c;
		int n;
		int hi;
		u_ttu_core_model.wr(ttu_pkg::ADDR_TC_LOW, 4'h0);
		u_ttu_core_model.wr(ttu_pkg::ADDR_TC_HIGH, 4'hf);
		u_ttu_core_model.wr(ttu_pkg::ADDR_TC_MODE, 4'hf);
		gap(2, n);
		chk(n[7:0], 8'd32, "timer c reload period");
		gap(3, n);
		chk(n[7:0], 8'd32, "watchdog period");
		hi = 0;
		repeat (64) begin
			@(posedge clk_sys);
			#1 hi += (pulse_q === 1'b1);
		end
		chk(hi[7:0], 8'h00, "pulse pin unrouted");
		u_ttu_core_model.wr(ttu_pkg::ADDR_PIN_FUNC, 4'h4);
		gap(2, n);
		hi = 0;
		// two whole periods of 16 counts, 15 of them above the duty
		repeat (64) begin
			@(posedge clk_sys);
			#1 hi += (pulse_q === 1'b1);
		end
		chk(hi[7:0], 8'd60, "pwm high time");
		$display("test timer_c done");
	endtask : t_timer_c

	task automatic t_stop;
		logic [3:0] d;
		u_ttu_core_model.wr(ttu_pkg::ADDR_CTRL, 4'h2);
		repeat (4) @(posedge clk_sys);
		#1 chk({7'h00, pulse_q}, 8'h00, "pulse pin in stop");
		u_ttu_core_model.wr(ttu_pkg::ADDR_CTRL, 4'h0);
		u_ttu_core_model.rd(ttu_pkg::ADDR_PIN_FUNC, d);
		chk({4'h0, d}, 8'h00, "pin select cleared");
		u_ttu_core_model.rd(ttu_pkg::ADDR_TA_MODE, d);
		chk({4'h0, d}, 8'h00, "timer a mode cleared");
		$display("test stop done");
	endtask : t_stop

	initial begin
		err_count = 0;
		compares = 0;
		rst = 1'b1;
		event_pin = 1'b0;
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset_map();
		t_load();
		t_periods();
		t_events();
		t_capture();
		t_timer_c();
		t_stop();
		test_done();
	end
endmodule : test_triple_timer_unit
